//--- rtl/srs_regs.vh
/*
  Offsets, field positions, reset values and sequence counts of the
  system reset and clock sequencer.
  Assumes a 32-bit APB where each register takes one aligned word.
*/
`ifndef SRS_REGS_VH
`define SRS_REGS_VH

// Register indices; byte address is four times the index
`define SRS_IDX_BREAK_STATUS  16'hFE00
`define SRS_IDX_RESET_CAUSE   16'hFE01
`define SRS_IDX_BREAK_CTRL    16'hFE03

// Reset cause fields
`define SRS_RC_POWER_UP  7
`define SRS_RC_PIN       6
`define SRS_RC_WATCHDOG  5
`define SRS_RC_BAD_OP    4
`define SRS_RC_BAD_ADDR  3
`define SRS_RC_LOW_SUP   1

// Break fields
`define SRS_BS_WAIT      1
`define SRS_BC_CLR_EN    7

// Reset values
`define SRS_RC_RESET     8'h80
`define SRS_BS_RESET     8'h00
`define SRS_BC_RESET     8'h00

// Sequence counts in reference clock cycles
`define SRS_POR_CYCLES   4096
`define SRS_DRIVE_CYCLES 32
`define SRS_HOLD_CYCLES  32
`define SRS_PIN_CYCLES   67
`define SRS_PIN_POR_CYC  4163

// Reset vectors
`define SRS_VEC_USER     16'hFFFE
`define SRS_VEC_MONITOR  16'hFEFE

`endif

//--- rtl/srs_top.v
/*
  System reset and clock sequencer: bus clock generation and gating,
  reset source sequencing, open-drain reset pin drive, reset cause and
  break status registers behind an APB slave.
  Assumes one reference clock, a synchronous active-low reset that
  stands for power-up, and a CPU that runs from the enables produced here.
*/
`timescale 1ns/1ps
`include "srs_regs.vh"

// Notes on behaviour
// - Bus clock is generated clock halved
// - Bus rate is reference or PLL over four
// - Power-up or low supply: clocks held 4096 cycles
// - Reset pin low during that timeout
// - Bus clocks start when timeout ends
// - Wait stops CPU clock, peripherals keep running
// - Every reset asserts reset, picks vector
// - Internal reset restores break register defaults
// - Internal reset clears prescaler; pin reset not
// - Each source sets its own cause flag
// - Pin low halts; flag after 67 cycles
// - After power-up or low supply, 4163 cycles
// - Internal sources drive pin 32 cycles
// - Internal reset stays 32 cycles more
// - Internal sources: address, opcode, watchdog, supply, power
// - Power/supply: 4096 pin-low, then sequence
// - Watchdog input treated as asynchronous
// - CPU released 64 cycles after count
// - Generated clock runs while CPU clocks stopped
// - Power-up sets its flag, clears others
// - Writing zero clears break wait status
// - Prescaler is thirteen bits, free running
// - Only opcode fetches outside memory reset
module srs_top #(
  parameter integer POR_CYCLES = `SRS_POR_CYCLES,
  parameter integer PIN_POR_CYC = `SRS_PIN_POR_CYC,
  parameter [15:0] ROM_LO = 16'h8000,
  parameter [15:0] ROM_HI = 16'hFFFF,
  parameter [15:0] RAM_LO = 16'h0060,
  parameter [15:0] RAM_HI = 16'h025F
) (
  // Clock, reset and enable
  input  wire        ref_clk_in,
  input  wire        rst_b_in,
  input  wire        clk_en_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [17:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg         pready_out,
  output reg  [31:0] prdata_out,
  output reg         pslverr_out,
  // Reset sources
  input  wire        power_up_pulse_in,
  input  wire        low_supply_in,
  input  wire        watchdog_timeout_in,
  input  wire        bad_opcode_in,
  input  wire        opcode_fetch_in,
  input  wire [15:0] internal_address_bus_in,
  // Open-drain reset pin
  input  wire        reset_pin_b_in,
  output reg         reset_pin_b_out,
  output reg         reset_pin_oe_out,
  // Clock control
  input  wire        pll_clock_in,
  input  wire        pll_select_in,
  input  wire        wait_mode_in,
  input  wire        monitor_mode_in,
  output reg         generated_clock_out,
  output reg         cpu_clock_out,
  output reg         periph_clock_out,
  // System status
  input  wire        break_wait_in,
  output reg         internal_reset_out,
  output reg  [15:0] reset_vector_out,
  output reg         break_flag_clear_enable_out
);

  ////////////////////////////////////////////////////////////////////
  // Constants and state codes
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_POR   = 3'h1;
  localparam [2:0] ST_DRIVE = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;
  localparam [2:0] ST_EXT   = 3'h4;
  // Last counts at full width, then cut to the counter widths
  localparam [31:0] POR_LAST_W     = POR_CYCLES - 1;
  localparam [31:0] PIN_LAST_W     = `SRS_PIN_CYCLES - 1;
  localparam [31:0] PIN_POR_LAST_W = PIN_POR_CYC - 1;
  localparam [31:0] DRIVE_LAST_W   = `SRS_DRIVE_CYCLES - 1;
  localparam [31:0] HOLD_LAST_W    = `SRS_HOLD_CYCLES - 1;
  localparam [12:0] POR_LAST = POR_LAST_W[12:0];
  localparam [12:0] PIN_LAST = PIN_LAST_W[12:0];
  localparam [12:0] PIN_POR_LAST = PIN_POR_LAST_W[12:0];
  localparam [5:0] DRIVE_LAST = DRIVE_LAST_W[5:0];
  localparam [5:0] HOLD_LAST = HOLD_LAST_W[5:0];
  localparam [17:0] ADDR_BS = {`SRS_IDX_BREAK_STATUS, 2'b00};
  localparam [17:0] ADDR_RC = {`SRS_IDX_RESET_CAUSE, 2'b00};
  localparam [17:0] ADDR_BC = {`SRS_IDX_BREAK_CTRL, 2'b00};

  ////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  wire [5:0] async_in = {pll_select_in, pll_clock_in, reset_pin_b_in,
                         watchdog_timeout_in, low_supply_in,
                         power_up_pulse_in};

  // Two flip-flops per asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      always @(posedge ref_clk_in)
      begin
        if (!rst_b_in)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else if (clk_en_in)
        begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire por_s  = sync_b[0];
  wire lvi_s  = sync_b[1];
  wire wd_s   = sync_b[2];
  wire pin_s  = sync_b[3];
  wire pll_s  = sync_b[4];
  wire psel_s = sync_b[5];

  ////////////////////////////////////////////////////////////////////
  // Event edge detection on synchronised levels
  reg  por_d;
  reg  lvi_d;
  reg  wd_d;
  reg  pll_d;

  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      por_d <= 1'b0;
      lvi_d <= 1'b0;
      wd_d  <= 1'b0;
      pll_d <= 1'b0;
    end
    else if (clk_en_in)
    begin
      por_d <= por_s;
      lvi_d <= lvi_s;
      wd_d  <= wd_s;
      pll_d <= pll_s;
    end
  end

  // Fetch address check against program memory and RAM
  wire addr_mapped = (internal_address_bus_in >= ROM_LO &&
                      internal_address_bus_in <= ROM_HI) ||
                     (internal_address_bus_in >= RAM_LO &&
                      internal_address_bus_in <= RAM_HI);
  wire ev_por  = por_s & ~por_d;
  wire ev_lvi  = lvi_s & ~lvi_d;
  wire ev_wd   = wd_s & ~wd_d;
  wire ev_op   = bad_opcode_in;
  wire ev_addr = opcode_fetch_in & ~addr_mapped;
  wire ev_long = ev_por | ev_lvi;
  wire ev_int  = ev_long | ev_wd | ev_op | ev_addr;

  ////////////////////////////////////////////////////////////////////
  // Reset sequencer with prescaler and phase counter
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [12:0] prescaler;
  reg  [5:0]  seq_cnt;
  reg  [5:0]  next_seq_cnt;
  reg         clr_presc;

  // Next state of the sequencer
  always @*
  begin
    next_state = state;
    next_seq_cnt = seq_cnt + 6'h01;
    clr_presc = 1'b0;
    if (ev_long)
    begin
      next_state = ST_POR;
      clr_presc = 1'b1;
    end
    else if (ev_int && state != ST_POR)
    begin
      next_state = ST_DRIVE;
      next_seq_cnt = 6'h00;
      clr_presc = 1'b1;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (!pin_s)
            next_state = ST_EXT;
        end
        ST_POR:
        begin
          next_seq_cnt = 6'h00;
          if (prescaler == POR_LAST)
            next_state = ST_DRIVE;
        end
        ST_DRIVE:
        begin
          if (seq_cnt == DRIVE_LAST)
          begin
            next_state = ST_HOLD;
            next_seq_cnt = 6'h00;
          end
        end
        ST_HOLD:
        begin
          if (seq_cnt == HOLD_LAST)
            next_state = ST_IDLE;
        end
        ST_EXT:
        begin
          if (pin_s)
            next_state = ST_IDLE;
        end
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // Sequencer registers; bus reset stands for power-up
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      state     <= ST_POR;
      seq_cnt   <= 6'h00;
      prescaler <= 13'h0000;
    end
    else if (clk_en_in)
    begin
      state   <= next_state;
      seq_cnt <= next_seq_cnt;
      if (clr_presc)
        prescaler <= 13'h0000;
      else
        prescaler <= prescaler + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin low duration measure for the pin cause flag
  reg  [12:0] pin_low_cnt;
  reg         long_seq;
  wire [12:0] pin_need = long_seq ? PIN_POR_LAST : PIN_LAST;
  wire        ev_pin = !pin_s && pin_low_cnt == pin_need;

  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      pin_low_cnt <= 13'h0000;
      long_seq    <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (pin_s)
        pin_low_cnt <= 13'h0000;
      else if (pin_low_cnt != 13'h1FFF)
        pin_low_cnt <= pin_low_cnt + 13'h0001;
      if (ev_long)
        long_seq <= 1'b1;
      else if (pin_s && state == ST_IDLE)
        long_seq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock generation: generated clock and bus clock enables
  reg  bus_phase;
  reg  clk_run;
  // Reference ticks every cycle; PLL ticks on its synchronised rising edge
  wire src_tick = psel_s ? (pll_s & ~pll_d) : 1'b1;
  wire gen_fall = src_tick & generated_clock_out;
  wire next_bus = gen_fall ? ~bus_phase : bus_phase;

  // Generated clock toggles on each source tick, bus on its halving
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      generated_clock_out <= 1'b0;
      bus_phase           <= 1'b0;
      clk_run             <= 1'b0;
      cpu_clock_out       <= 1'b0;
      periph_clock_out    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (src_tick)
        generated_clock_out <= ~generated_clock_out;
      bus_phase        <= next_bus;
      clk_run          <= (next_state != ST_POR);
      cpu_clock_out    <= next_bus & clk_run & ~wait_mode_in;
      periph_clock_out <= next_bus & clk_run;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset pin, internal reset and vector outputs
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      reset_pin_b_out    <= 1'b0;
      reset_pin_oe_out   <= 1'b1;
      internal_reset_out <= 1'b1;
      reset_vector_out   <= `SRS_VEC_USER;
    end
    else if (clk_en_in)
    begin
      reset_pin_b_out  <= 1'b0;
      reset_pin_oe_out <= (next_state == ST_POR) ||
                          (next_state == ST_DRIVE);
      internal_reset_out <= (next_state != ST_IDLE);
      if (monitor_mode_in)
        reset_vector_out <= `SRS_VEC_MONITOR;
      else
        reset_vector_out <= `SRS_VEC_USER;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then data and pready together
  wire acc     = psel_in & penable_in;
  wire wr_fire = acc & pready_out & pwrite_in;
  wire hit_bs  = (paddr_in == ADDR_BS);
  wire hit_rc  = (paddr_in == ADDR_RC);
  wire hit_bc  = (paddr_in == ADDR_BC);
  reg  [7:0] reset_cause;
  reg  [7:0] break_status;
  reg  [7:0] break_ctrl;
  reg  [7:0] rd_mux;

  // Read data selection
  always @*
  begin
    if (hit_bs)
      rd_mux = break_status;
    else if (hit_rc)
      rd_mux = reset_cause;
    else if (hit_bc)
      rd_mux = break_ctrl;
    else
      rd_mux = 8'h00;
  end

  // Handshake, read data and error answer
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pready_out  <= acc & ~pready_out;
      pslverr_out <= acc & ~pready_out & ~(hit_bs | hit_rc | hit_bc);
      if (acc & ~pready_out & ~pwrite_in)
        prdata_out <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset cause register; flags accumulate until power-up reloads the reset value
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      reset_cause <= `SRS_RC_RESET;
    else if (clk_en_in)
    begin
      if (ev_por)
        reset_cause <= `SRS_RC_RESET;
      else
      begin
        if (ev_pin)
          reset_cause[`SRS_RC_PIN] <= 1'b1;
        if (ev_wd)
          reset_cause[`SRS_RC_WATCHDOG] <= 1'b1;
        if (ev_op)
          reset_cause[`SRS_RC_BAD_OP] <= 1'b1;
        if (ev_addr)
          reset_cause[`SRS_RC_BAD_ADDR] <= 1'b1;
        if (ev_lvi)
          reset_cause[`SRS_RC_LOW_SUP] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Break status and break control; defaults under internal reset
  always @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      break_status <= `SRS_BS_RESET;
      break_ctrl   <= `SRS_BC_RESET;
      break_flag_clear_enable_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (internal_reset_out)
      begin
        break_status <= `SRS_BS_RESET;
        break_ctrl   <= `SRS_BC_RESET;
      end
      else
      begin
        if (break_wait_in)
          break_status[`SRS_BS_WAIT] <= 1'b1;
        else if (wr_fire && hit_bs && !pwdata_in[`SRS_BS_WAIT])
          break_status[`SRS_BS_WAIT] <= 1'b0;
        if (wr_fire && hit_bc)
          break_ctrl[`SRS_BC_CLR_EN] <= pwdata_in[`SRS_BC_CLR_EN];
      end
      break_flag_clear_enable_out <= break_ctrl[`SRS_BC_CLR_EN];
    end
  end

endmodule

//--- tb/srs_chk_assertions.sv
/*
  Port checker for the reset and clock sequencer.
  Assumes it is bound into srs_top and shares its parameters.
*/
`timescale 1ns/1ps
module srs_chk #(
  parameter integer POR_CYCLES = 4096,
  parameter [15:0]  ROM_LO     = 16'h8000,
  parameter [15:0]  ROM_HI     = 16'hFFFF,
  parameter [15:0]  RAM_LO     = 16'h0060,
  parameter [15:0]  RAM_HI     = 16'h025F
) (
  // Clock and reset
  input wire        ref_clk_in,
  input wire        rst_b_in,
  // APB
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire        pready_out,
  input wire [31:0] prdata_out,
  input wire        pslverr_out,
  // Sources and pin
  input wire        bad_opcode_in,
  input wire        opcode_fetch_in,
  input wire [15:0] internal_address_bus_in,
  input wire        reset_pin_b_in,
  input wire        reset_pin_oe_out,
  // Clocks and status
  input wire        pll_select_in,
  input wire        wait_mode_in,
  input wire        monitor_mode_in,
  input wire        generated_clock_out,
  input wire        cpu_clock_out,
  input wire        internal_reset_out,
  input wire [15:0] reset_vector_out
);
  reg  [15:0] oe_cnt;
  reg  [7:0]  hold_cnt;
  reg         drv;
  wire        in_rom = internal_address_bus_in >= ROM_LO && internal_address_bus_in <= ROM_HI;
  wire        in_ram = internal_address_bus_in >= RAM_LO && internal_address_bus_in <= RAM_HI;
  ////////////////////////////////////////////////////////////////
  // Length of each pin drive and of the hold that follows it
  always @(posedge ref_clk_in)
    if (!rst_b_in)
    begin
      oe_cnt   <= 16'h0000;
      hold_cnt <= 8'h00;
      drv      <= 1'b1;
    end
    else
    begin
      oe_cnt   <= reset_pin_oe_out ? oe_cnt + 16'h0001 : 16'h0000;
      hold_cnt <= (reset_pin_oe_out || !internal_reset_out) ? 8'h00 : hold_cnt + 8'h01;
      drv      <= reset_pin_oe_out | (drv & internal_reset_out);
    end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////
  a_opcode_reset:
    assert property (bad_opcode_in |=> reset_pin_oe_out && internal_reset_out)
    else $error("opcode fault gave no reset");
  a_fetch_reset:
    assert property (opcode_fetch_in && !in_rom && !in_ram |=> internal_reset_out)
    else $error("bad fetch gave no reset");
  a_drive_len:
    assert property ($fell(reset_pin_oe_out) |-> oe_cnt == 32 || oe_cnt == POR_CYCLES + 32)
    else $error("pin drive length wrong");
  a_hold_len:
    assert property ($fell(internal_reset_out) && drv |-> hold_cnt == 8'h20)
    else $error("reset hold length wrong");
  a_pin_halts:
    assert property ($fell(reset_pin_b_in) && !reset_pin_oe_out && !internal_reset_out
                     |-> ##[1:4] internal_reset_out)
    else $error("pin low did not halt");
  a_vector_pick:
    assert property ($stable(monitor_mode_in)[*3] ##0 internal_reset_out
                     |-> reset_vector_out == (monitor_mode_in ? 16'hFEFE : 16'hFFFE))
    else $error("reset vector wrong");
  a_wait_stop:
    assert property (wait_mode_in[*3] |-> !cpu_clock_out)
    else $error("cpu clock runs in wait");
  a_gen_toggle:
    assert property ((rst_b_in && !pll_select_in)[*4] |-> $changed(generated_clock_out))
    else $error("generated clock stalled");
  a_apb_answer:
    assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready after access");
  a_ready_pulse:
    assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_data:
    assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h00000000)
    else $error("error read not zero");
  c_hold: cover property ($fell(internal_reset_out) && drv);
  c_err: cover property (pready_out && pslverr_out);
  c_drive: cover property ($rose(reset_pin_oe_out));
endmodule

bind srs_top srs_chk #(.POR_CYCLES(POR_CYCLES), .ROM_LO(ROM_LO), .ROM_HI(ROM_HI),
  .RAM_LO(RAM_LO), .RAM_HI(RAM_HI)) u_chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out), .bad_opcode_in(bad_opcode_in),
  .opcode_fetch_in(opcode_fetch_in), .internal_address_bus_in(internal_address_bus_in),
  .reset_pin_b_in(reset_pin_b_in), .reset_pin_oe_out(reset_pin_oe_out),
  .pll_select_in(pll_select_in), .wait_mode_in(wait_mode_in),
  .monitor_mode_in(monitor_mode_in), .generated_clock_out(generated_clock_out),
  .cpu_clock_out(cpu_clock_out), .internal_reset_out(internal_reset_out),
  .reset_vector_out(reset_vector_out));

//--- tb/srs_pin_model.sv
/*
  Board side of the reset wire: pull-up plus a device that holds it low.
  Assumes the sequencer drives the wire open drain, low only.
*/
`timescale 1ns/1ps
module srs_pin_model (
  // Clock and request
  input  wire       ref_clk_in,
  input  wire       go_in,
  input  wire [7:0] low_len_in,
  // Sequencer drive and wire level
  input  wire       drive_b_in,
  input  wire       drive_oe_in,
  output wire       pin_level_out
);
  reg [7:0] left = 8'h00;
  // Hold the wire low for the requested count after a go pulse
  always @(posedge ref_clk_in)
    if (go_in)
      left <= low_len_in;
    else if (left != 8'h00)
      left <= left - 8'h01;
  // Pull-up wins unless some party pulls low
  assign pin_level_out = (left == 8'h00) & (drive_oe_in ? drive_b_in : 1'b1);
endmodule

//--- tb/tb.sv
/*
  Self-checking bench for the sequencer: APB master, source pulses,
  reset wire partner and a model of the cause and break registers.
  Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`include "srs_regs.vh"
module tb;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [17:0] paddr = 18'h00000;
  reg  [31:0] pwdata = 32'h0;
  reg         pwr = 1'b0, lowv = 1'b0, wdog = 1'b0, badop = 1'b0, fetch = 1'b0;
  reg         wmode = 1'b0, mon = 1'b0, bwait = 1'b0, go = 1'b0;
  reg  [15:0] internal_address_bus = 16'h0000;
  reg  [7:0]  plen = 8'h00;
  wire        pready, pslverr, pin, pin_out, pin_oe, gclk, cpuclk, pclk, internal_reset, break_flag_clear_enable;
  wire [31:0] prdata;
  wire [15:0] vec;
  integer     err_total = 0, cmp_count = 0, cyc = 0, exp_cause = 32'h80, i, n, seed;
  int         src_bit[$] = '{4, 3, 5, 1};
  ////////////////////////////////////////////////////////////////
  initial forever #4 clk = ~clk;
  srs_top #(.POR_CYCLES(64), .PIN_POR_CYC(131)) u_dut (
    .ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .power_up_pulse_in(pwr), .low_supply_in(lowv), .watchdog_timeout_in(wdog),
    .bad_opcode_in(badop), .opcode_fetch_in(fetch), .internal_address_bus_in(internal_address_bus),
    .reset_pin_b_in(pin), .reset_pin_b_out(pin_out), .reset_pin_oe_out(pin_oe),
    .pll_clock_in(1'b0), .pll_select_in(1'b0), .wait_mode_in(wmode),
    .monitor_mode_in(mon), .generated_clock_out(gclk), .cpu_clock_out(cpuclk),
    .periph_clock_out(pclk), .break_wait_in(bwait), .internal_reset_out(internal_reset),
    .reset_vector_out(vec), .break_flag_clear_enable_out(break_flag_clear_enable));
  srs_pin_model u_pin (.ref_clk_in(clk), .go_in(go), .low_len_in(plen),
    .drive_b_in(pin_out), .drive_oe_in(pin_oe), .pin_level_out(pin));
  ////////////////////////////////////////////////////////////////
  task test_done;
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compare one value with the model
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
           input logic [31:0] ex, input logic er);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (!w) chk(prdata, ex);
    chk(pslverr, er);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for the internal reset to reach a level
  task wait_ir(input logic v);
    n = 0;
    do @(negedge clk); while (internal_reset !== v && ++n < 400);
    chk(internal_reset, v);
  endtask
  // Pulse a source for one cycle
  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: badop <= 1'b1;
      1: begin fetch <= 1'b1; internal_address_bus <= 16'h4000; end
      2: wdog <= 1'b1;
      3: lowv <= 1'b1;
      4: pwr <= 1'b1;
      default: bwait <= 1'b1;
    endcase
    @(posedge clk);
    {badop, fetch, wdog, lowv, pwr, bwait} <= 6'h00;
  endtask
  // Clock cycle ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    seed = $urandom(80052);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(pin_oe, 1);
    chk(vec, 16'hFFFE);
    repeat (8) begin @(negedge clk); chk(cpuclk | pclk, 0); end
    apb(0, `SRS_IDX_RESET_CAUSE, 0, exp_cause, 0);
    wait_ir(0);
    n = 0;
    repeat (8) begin @(negedge clk); n += pclk; end
    chk(n, 4);
    @(posedge clk);
    wmode <= 1'b1;
    repeat (3) @(negedge clk);
    n = 0;
    repeat (8) begin @(negedge clk); n += cpuclk + 2 * pclk; end
    chk(n, 8);
    @(posedge clk);
    wmode <= 1'b0;
    // Opcode fetches inside RAM and a data fetch at unmapped 16'h4000 are harmless
    repeat (8) begin @(posedge clk); fetch <= 1'b1; internal_address_bus <= 16'h0060 + $urandom % 16'h0200; end
    @(posedge clk); fetch <= 1'b0; internal_address_bus <= 16'h4000;
    repeat (4) @(negedge clk);
    chk(internal_reset, 0);
    for (i = 0; i < 4; i++)
    begin
      pulse(i);
      wait_ir(1);
      wait_ir(0);
      exp_cause |= 1 << src_bit[i];
      apb(0, `SRS_IDX_RESET_CAUSE, 0, exp_cause, 0);
    end
    mon <= 1'b1;
    pulse(0);
    wait_ir(1);
    @(negedge clk);
    chk(vec, 16'hFEFE);
    wait_ir(0);
    @(posedge clk);
    mon <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk); plen <= i ? 8'h64 : 8'h14; go <= 1'b1;
      @(posedge clk); go <= 1'b0;
      wait_ir(1);
      chk(pin_oe, 0);
      wait_ir(0);
      if (i) exp_cause |= 32'h40;
      apb(0, `SRS_IDX_RESET_CAUSE, 0, exp_cause, 0);
    end
    pulse(5);
    apb(0, `SRS_IDX_BREAK_STATUS, 0, 32'h02, 0);
    apb(1, `SRS_IDX_BREAK_STATUS, 32'h0, 0, 0);
    apb(0, `SRS_IDX_BREAK_STATUS, 0, 32'h00, 0);
    apb(1, `SRS_IDX_BREAK_CTRL, 32'h80, 0, 0);
    repeat (2) @(negedge clk);
    chk(break_flag_clear_enable, 1);
    apb(0, `SRS_IDX_BREAK_CTRL, 0, 32'h80, 0);
    apb(0, 16'hFE02, 0, 0, 1);
    apb(1, `SRS_IDX_RESET_CAUSE, 32'hFF, 0, 0);
    apb(0, `SRS_IDX_RESET_CAUSE, 0, exp_cause, 0);
    pulse(4);
    wait_ir(1);
    apb(0, `SRS_IDX_BREAK_CTRL, 0, 32'h00, 0);
    wait_ir(0);
    chk(break_flag_clear_enable, 0);
    apb(0, `SRS_IDX_RESET_CAUSE, 0, 32'h80, 0);
    test_done;
  end
endmodule
